// *** logic/accumulator_extract_unit.sv ***
// Extraction of bitfields and shifted values from four wide accumulators.
`include "acc_extract_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of the block.
// The unit holds four wide accumulators, each built from a high and a low 64-bit half.
// Software loads and reads the halves and the status word through a plain register port.
// The pipeline issues one decoded instruction per cycle, and the answer comes one cycle later.
// An answer is a writeback pulse, a reserved-instruction pulse or a disabled pulse, never two at once.
//
// Register map, byte offsets on the register port.
// The status word sits at offset zero, in the low half of the 64-bit bus.
// Accumulator n keeps its high half at the base offset plus n strides.
// Its low half sits one half-stride above the high half.
// Offsets that match nothing read as zero, and writes to them are dropped.
// Reserved status bits ignore writes and always read as zero.
//
// Status word layout.
// The low seven bits hold the start index of the next bitfield extraction.
// One bit records whether the last bitfield extraction failed.
// One bit is the sticky overflow flag of the rounding forms.
// Software may clear the sticky flag, but an overflow in the same cycle keeps it set.
//
// Instruction word layout.
// The top six bits and the low six bits together select this group of operations.
// Bits ten down to six choose the operation within the group.
// Bits twelve and eleven choose the accumulator.
// Bits twenty down to sixteen name the destination register.
// Bits twenty-five down to twenty-one hold the shift amount of the shift forms.
// Codes of the group that are not served here are answered as reserved when enabled, and as disabled otherwise.
//
// Bitfield extraction.
// The field starts at the stored index and runs downwards for size plus one bits.
// The size comes from the low six bits of the source value, the rest is ignored.
// A field that would run below bit zero fails, writes back zero and raises the failure bit.
// The decrementing form moves the index down past the field only when it succeeds.
// An index equal to the size decrements to all ones; software must reload it before reuse.
//
// Shift extraction.
// The shift core sees the accumulator with one guard bit appended below.
// Rounding adds one at the guard bit, so a half step rounds up towards plus infinity, also for negative values.
// Overflow is judged on the rounded value, before any clamp is applied.
// Only the rounding forms ever raise the sticky flag.
//
// Hazards.
// Status effects of one instruction are visible to the very next one.
// An instruction and a software status write in one cycle: the instruction's effect wins.
// Accumulators are never touched by an instruction, only by the register port.
// A data value never raises an exception; only decode and enable faults are reported.

module accumulator_extract_unit
	import acc_extract_pkg::*;
#(
	parameter int ACC_COUNT = 4
)
(
	input  wire logic        MCLK_I,
	input  wire logic        RST_I,
	input  wire logic        ISSUE_VALID_I,
	input  wire logic [31:0] INSTR_I,
	input  wire logic [63:0] SRC_VALUE_I,
	input  wire logic        EXT_ENABLE_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [63:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic [63:0]      REG_RDATA_O,
	output logic             WB_VALID_O,
	output logic [4:0]       WB_DEST_O,
	output logic [63:0]      WB_DATA_O,
	output logic             EXC_RESERVED_O,
	output logic             EXC_DISABLED_O
);

	// The select field is two bits wide, so at most four accumulators exist.
	if (ACC_COUNT < 1 || ACC_COUNT > 4) begin : g_bad_count
		$error("ACC_COUNT must lie between 1 and 4");
	end

	// The start index field must stay seven bits wide for the position arithmetic below.
	if ((`POS_MSB - `POS_LSB) != 6) begin : g_bad_pos
		$error("start index field must be seven bits wide");
	end

	// Both flags must sit inside the 32-bit status word.
	if ((`FAIL_BIT > 31) || (`OUFLAG_BIT > 31)) begin : g_bad_flags
		$error("status flags must lie inside the status word");
	end

	// Accumulator storage, high and low halves.
	logic [63:0]    acc_hi_reg [ACC_COUNT];
	logic [63:0]    acc_lo_reg [ACC_COUNT];

	// Status register and its next value.
	logic [31:0]    status_reg;
	logic [31:0]    status_next;

	// Registered outputs.
	writeback_t     wb_reg;
	writeback_t     wb_next;
	logic           exc_res_reg;
	logic           exc_dis_reg;
	logic [63:0]    rdata_reg;
	logic [63:0]    rdata_next;

	// Decode and datapath signals.
	decoded_instr_t dec;
	logic           ours;
	logic           go;
	logic           is_field;
	logic           is_shift;
	logic [127:0]   acc_sel_val;
	logic [6:0]     start_pos;
	logic [5:0]     size;
	logic           field_ok;
	logic [6:0]     low_pos;
	logic [6:0]     new_pos;
	logic [127:0]   field_shifted;
	logic [63:0]    field_mask;
	logic [63:0]    field_val;
	shift_mode_t    mode;
	logic [63:0]    shift_result;
	logic           shift_ovf;

	// Recognise the extraction group and map the sub-operation to an operation.
	always_comb begin
		dec.shift   = INSTR_I[25:21];
		dec.dest    = INSTR_I[20:16];
		dec.acc_sel = INSTR_I[12:11];
		ours = (INSTR_I[31:26] == `MAJOR_GROUP) && (INSTR_I[5:0] == `FUNC_EXTRACT);
		case (INSTR_I[10:6])
			`SUB_VAR_FIELD: begin
				dec.op = OP_VAR_FIELD;
			end
			`SUB_VAR_DEC: begin
				dec.op = OP_VAR_FIELD_DEC;
			end
			`SUB_DW: begin
				dec.op = OP_SHIFT_DWORD;
			end
			`SUB_DW_RND: begin
				dec.op = OP_SHIFT_DWORD_RND;
			end
			`SUB_DW_SAT: begin
				dec.op = OP_SHIFT_DWORD_SAT;
			end
			`SUB_W: begin
				dec.op = OP_SHIFT_WORD;
			end
			`SUB_W_RND: begin
				dec.op = OP_SHIFT_WORD_RND;
			end
			`SUB_W_SAT: begin
				dec.op = OP_SHIFT_WORD_SAT;
			end
			default: begin
				dec.op = OP_RESERVED;
			end
		endcase
		if (!ours) begin
			dec.op = OP_NONE;
		end
	end

	// An instruction executes only when enabled and known.
	always_comb begin
		go       = ISSUE_VALID_I && EXT_ENABLE_I && (dec.op != OP_NONE) && (dec.op != OP_RESERVED);
		is_field = go && ((dec.op == OP_VAR_FIELD) || (dec.op == OP_VAR_FIELD_DEC));
		is_shift = go && !is_field;
	end

	// Operation to shift mode.
	always_comb begin
		mode.round = 1'b0;
		mode.sat   = 1'b0;
		mode.word  = 1'b0;
		case (dec.op)
			OP_SHIFT_DWORD_RND: begin
				mode.round = 1'b1;
			end
			OP_SHIFT_DWORD_SAT: begin
				mode.round = 1'b1;
				mode.sat   = 1'b1;
			end
			OP_SHIFT_WORD: begin
				mode.word = 1'b1;
			end
			OP_SHIFT_WORD_RND: begin
				mode.round = 1'b1;
				mode.word  = 1'b1;
			end
			OP_SHIFT_WORD_SAT: begin
				mode.round = 1'b1;
				mode.sat   = 1'b1;
				mode.word  = 1'b1;
			end
			default: begin
				mode.round = 1'b0;
			end
		endcase
	end

	// Accumulator selection; an absent accumulator reads as zero.
	always_comb begin
		acc_sel_val = '0;
		for (int i = 0; i < ACC_COUNT; i++) begin
			if (int'(dec.acc_sel) == i) begin
				acc_sel_val = {acc_hi_reg[i], acc_lo_reg[i]};
			end
		end
	end

	// Bitfield extraction from the position held in the status register.
	always_comb begin
		start_pos     = status_reg[`POS_MSB:`POS_LSB];
		size          = SRC_VALUE_I[5:0];
		field_ok      = {1'b0, start_pos} >= {2'b00, size};
		low_pos       = start_pos - {1'b0, size};
		new_pos       = start_pos - {1'b0, size} - 7'h01;
		field_shifted = acc_sel_val >> low_pos;
		field_mask    = ~(64'hffff_ffff_ffff_ffff << ({1'b0, size} + 7'h01));
		field_val     = field_ok ? (field_shifted[63:0] & field_mask) : 64'h0;
	end

	// Fixed shift datapath with rounding and saturation.
	shift_round_core u_core (
		.acc_i      (acc_sel_val),
		.shift_i    ({1'b0, dec.shift}),
		.mode_i     (mode),
		.result_o   (shift_result),
		.overflow_o (shift_ovf)
	);

	// Software write first, then the instruction's effects, so a hardware set wins.
	always_comb begin
		status_next = status_reg;
		if (REG_WR_I && (REG_ADDR_I == `OFS_STATUS)) begin
			status_next = REG_WDATA_I[31:0] & `STATUS_WR_MASK;
		end
		if (is_field) begin
			status_next[`FAIL_BIT] = !field_ok;
			if ((dec.op == OP_VAR_FIELD_DEC) && field_ok) begin
				status_next[`POS_MSB:`POS_LSB] = new_pos;
			end
		end
		if (is_shift && shift_ovf) begin
			status_next[`OUFLAG_BIT] = 1'b1;
		end
	end

	// Status register update.
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			status_reg <= `STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// Accumulators change only through the register port, never by an extraction.
	for (genvar g = 0; g < ACC_COUNT; g++) begin : g_acc
		localparam logic [7:0] HI_OFS = 8'(`OFS_ACC_BASE + g * `OFS_ACC_STRIDE);
		localparam logic [7:0] LO_OFS = 8'(HI_OFS + `OFS_ACC_LO_DELTA);
		always_ff @(posedge MCLK_I or posedge RST_I) begin
			if (RST_I) begin
				acc_hi_reg[g] <= 64'h0;
				acc_lo_reg[g] <= 64'h0;
			end else begin
				if (REG_WR_I && (REG_ADDR_I == HI_OFS)) begin
					acc_hi_reg[g] <= REG_WDATA_I;
				end
				if (REG_WR_I && (REG_ADDR_I == LO_OFS)) begin
					acc_lo_reg[g] <= REG_WDATA_I;
				end
			end
		end
	end

	// Register read decode; an unmapped offset reads as zero.
	always_comb begin
		rdata_next = 64'h0;
		if (REG_ADDR_I == `OFS_STATUS) begin
			rdata_next = {32'h0, status_reg};
		end
		for (int i = 0; i < ACC_COUNT; i++) begin
			if (REG_ADDR_I == 8'(`OFS_ACC_BASE + i * `OFS_ACC_STRIDE)) begin
				rdata_next = acc_hi_reg[i];
			end
			if (REG_ADDR_I == 8'(`OFS_ACC_BASE + i * `OFS_ACC_STRIDE + `OFS_ACC_LO_DELTA)) begin
				rdata_next = acc_lo_reg[i];
			end
		end
	end

	// Read data stands for the one cycle after the read strobe.
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_reg <= 64'h0;
		end else if (REG_RD_I) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 64'h0;
		end
	end

	// Writeback value for an executed instruction.
	always_comb begin
		wb_next.valid = go;
		wb_next.dest  = dec.dest;
		wb_next.data  = is_field ? field_val : shift_result;
		if (!go) begin
			wb_next.data = 64'h0;
		end
	end

	// Writeback register, one cycle after issue.
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			wb_reg <= '0;
		end else begin
			wb_reg <= wb_next;
		end
	end

	// Only decode and enable faults are reported, never data faults.
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			exc_res_reg <= 1'b0;
			exc_dis_reg <= 1'b0;
		end else begin
			exc_res_reg <= ISSUE_VALID_I && EXT_ENABLE_I && (dec.op == OP_RESERVED);
			exc_dis_reg <= ISSUE_VALID_I && !EXT_ENABLE_I && (dec.op != OP_NONE);
		end
	end

	// Output drive.
	assign REG_RDATA_O    = rdata_reg;
	assign WB_VALID_O     = wb_reg.valid;
	assign WB_DEST_O      = wb_reg.dest;
	assign WB_DATA_O      = wb_reg.data;
	assign EXC_RESERVED_O = exc_res_reg;
	assign EXC_DISABLED_O = exc_dis_reg;

endmodule
`default_nettype wire

// *** logic/acc_extract_params.svh ***
// Constants of the accumulator extraction unit.
// Function
// - Start index from status bits six down to zero.
// - Two-bit select picks one of four accumulators.
// - Extractions never change any accumulator.
// - Field valid only when start minus size+1 >= -1.
// - Decrementing form lowers index by size+1 when valid.
// - Failure bit fourteen set when invalid, else cleared.
// - Plain variable form keeps the start index.
// - Size is source register bits five to zero.
// - Field zero-extended to 64 bits and written back.
// - Doubleword form writes low 64 of arithmetic shift.
// - Shift amount is five-bit field zero-extended.
// - Rounding adds one at top discarded bit.
// - Doubleword saturation clamps to signed extremes.
// - Rounding overflow sets sticky status bit 23.
// - Word forms sign-extend low 32 result bits.
// - Word saturation clamps positive to 0x7fffffff.
// - Shift intermediate is 129 bits with guard bit.
// - No data-dependent exceptions are raised.
// - Variable field opcode group, function, sub-op decoded.
// - Doubleword sub-ops 10000, 10100, 10110 decoded.
// - Word sub-ops 00000, 00100, 00110 decoded.
`ifndef ACC_EXTRACT_PARAMS_SVH
`define ACC_EXTRACT_PARAMS_SVH

// Register map on the plain register port, byte offsets.
`define OFS_STATUS       8'h00
`define OFS_ACC_BASE     8'h10
`define OFS_ACC_STRIDE   8'h10
`define OFS_ACC_LO_DELTA 8'h08

// Status register layout and reset value.
`define POS_LSB          0
`define POS_MSB          6
`define FAIL_BIT         14
`define OUFLAG_BIT       23
`define STATUS_RESET     32'h0000_0000
`define STATUS_WR_MASK   32'h0080_407f

// Instruction encoding.
`define MAJOR_GROUP      6'h1f
`define FUNC_EXTRACT     6'h3c
`define SUB_VAR_FIELD    5'h03
`define SUB_VAR_DEC      5'h0b
`define SUB_DW           5'h10
`define SUB_DW_RND       5'h14
`define SUB_DW_SAT       5'h16
`define SUB_W            5'h00
`define SUB_W_RND        5'h04
`define SUB_W_SAT        5'h06

// Saturation limits.
`define SAT_DW_MAX       64'h7fff_ffff_ffff_ffff
`define SAT_DW_MIN       64'h8000_0000_0000_0000
`define SAT_W_MAX        32'h7fff_ffff
`define SAT_W_MIN        32'h8000_0000

`endif

// *** logic/acc_extract_pkg.sv ***
// Types shared by the accumulator extraction unit.
`default_nettype none
package acc_extract_pkg;

	// Decoded operation of one issued instruction.
	typedef enum logic [3:0] {
		OP_NONE,
		OP_VAR_FIELD,
		OP_VAR_FIELD_DEC,
		OP_SHIFT_DWORD,
		OP_SHIFT_DWORD_RND,
		OP_SHIFT_DWORD_SAT,
		OP_SHIFT_WORD,
		OP_SHIFT_WORD_RND,
		OP_SHIFT_WORD_SAT,
		OP_RESERVED
	} extract_op_t;

	// Fields of an issued instruction after decode.
	typedef struct packed {
		extract_op_t op;
		logic [4:0]  shift;
		logic [4:0]  dest;
		logic [1:0]  acc_sel;
	} decoded_instr_t;

	// Rounding and width selection for the shift datapath.
	typedef struct packed {
		logic round;
		logic sat;
		logic word;
	} shift_mode_t;

	// Result handed back to the pipeline.
	typedef struct packed {
		logic        valid;
		logic [4:0]  dest;
		logic [63:0] data;
	} writeback_t;

endpackage
`default_nettype wire

// *** logic/shift_round_core.sv ***
// Arithmetic shift, rounding and saturation of one accumulator.
`include "acc_extract_params.svh"
`timescale 1ns/1ps
`default_nettype none
module shift_round_core
	import acc_extract_pkg::*;
(
	input  wire logic [127:0] acc_i,
	input  wire logic [5:0]   shift_i,
	input  wire shift_mode_t  mode_i,
	output logic [63:0]       result_o,
	output logic              overflow_o
);

	logic [128:0] shifted;
	logic [128:0] chosen;
	logic         dw_ovf;
	logic         w_ovf;
	logic [31:0]  word_val;

	// Appending a zero below and shifting arithmetically yields the guard bit for free.
	always_comb begin
		shifted = 129'($signed({acc_i, 1'b0}) >>> shift_i);
		chosen  = mode_i.round ? (shifted + 129'h1) : shifted;
	end

	// Overflow means the bits above the kept result are not a pure sign fill.
	always_comb begin
		dw_ovf     = (chosen[128:64] != '0) && (chosen[128:64] != '1);
		w_ovf      = (chosen[128:32] != '0) && (chosen[128:32] != '1);
		overflow_o = mode_i.round && (mode_i.word ? w_ovf : dw_ovf);
	end

	// Select and clamp the written value.
	always_comb begin
		word_val = chosen[32:1];
		if (mode_i.sat && w_ovf) begin
			word_val = chosen[128] ? `SAT_W_MIN : `SAT_W_MAX;
		end
		if (mode_i.word) begin
			result_o = {{32{word_val[31]}}, word_val};
		end else if (mode_i.sat && dw_ovf) begin
			result_o = chosen[128] ? `SAT_DW_MIN : `SAT_DW_MAX;
		end else begin
			result_o = chosen[64:1];
		end
	end

endmodule
`default_nettype wire

// *** tb/acc_extract_chk.sv ***
// Port assertions for the accumulator extraction unit.
`include "acc_extract_params.svh"
`timescale 1ns/1ps
`default_nettype none
module acc_extract_chk (
	input wire logic        MCLK_I,
	input wire logic        RST_I,
	input wire logic        ISSUE_VALID_I,
	input wire logic [31:0] INSTR_I,
	input wire logic [63:0] SRC_VALUE_I,
	input wire logic        EXT_ENABLE_I,
	input wire logic        WB_VALID_O,
	input wire logic [4:0]  WB_DEST_O,
	input wire logic [63:0] WB_DATA_O,
	input wire logic        EXC_RESERVED_O,
	input wire logic        EXC_DISABLED_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	logic hit;
	logic known;
	// Decode of an issued instruction of this group.
	assign hit = ISSUE_VALID_I && INSTR_I[31:26] == `MAJOR_GROUP && INSTR_I[5:0] == `FUNC_EXTRACT;
	assign known = INSTR_I[10:6] inside {`SUB_VAR_FIELD, `SUB_VAR_DEC, `SUB_DW, `SUB_DW_RND, `SUB_DW_SAT,
		`SUB_W, `SUB_W_RND, `SUB_W_SAT};
	a_wb_follows: assert property (hit && EXT_ENABLE_I && known |=> WB_VALID_O && !EXC_RESERVED_O)
		else $error("writeback missing");
	a_reserved_pulse: assert property (hit && EXT_ENABLE_I && !known |=> EXC_RESERVED_O && !WB_VALID_O)
		else $error("reserved pulse missing");
	a_disabled_pulse: assert property (hit && !EXT_ENABLE_I |=> EXC_DISABLED_O && !WB_VALID_O)
		else $error("disabled pulse missing");
	a_foreign_quiet: assert property (ISSUE_VALID_I && !hit |=> !WB_VALID_O && !EXC_RESERVED_O)
		else $error("foreign opcode answered");
	a_exc_cause: assert property (EXC_RESERVED_O || EXC_DISABLED_O |-> $past(hit))
		else $error("exception without issue");
	a_dest_field: assert property (WB_VALID_O |-> WB_DEST_O == $past(INSTR_I[20:16]))
		else $error("wrong destination");
	a_word_sext: assert property (hit && EXT_ENABLE_I && INSTR_I[10:6] inside {`SUB_W, `SUB_W_RND, `SUB_W_SAT}
		|=> WB_DATA_O[63:32] == {32{WB_DATA_O[31]}}) else $error("word not sign extended");
	a_field_zext: assert property (hit && EXT_ENABLE_I && INSTR_I[10:6] inside {`SUB_VAR_FIELD, `SUB_VAR_DEC}
		|=> ((WB_DATA_O >> $past(SRC_VALUE_I[5:0])) >> 1) == 64'h0) else $error("field too wide");
endmodule
bind accumulator_extract_unit acc_extract_chk u_chk (.*);
`default_nettype wire

// *** tb/pipe_model.sv ***
// Model of the pipeline that issues instructions and takes results.
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
	input  wire logic        clk_i,
	input  wire logic        wb_valid_i,
	input  wire logic [63:0] wb_data_i,
	input  wire logic        exc_res_i,
	input  wire logic        exc_dis_i,
	output logic             issue_valid_o,
	output logic [31:0]      instr_o,
	output logic [63:0]      src_o
);
	logic [66:0] got;
	// Lines start idle.
	initial begin
		issue_valid_o = 1'b0;
		instr_o = 32'h0;
		src_o = 64'h0;
	end
	// One issue; lines are scrambled after release so nothing stale lingers.
	task automatic issue(input logic [31:0] ins, input logic [63:0] src);
		@(posedge clk_i);
		issue_valid_o <= 1'b1;
		instr_o <= ins;
		src_o <= src;
		@(posedge clk_i);
		issue_valid_o <= 1'b0;
		instr_o <= ~ins;
		src_o <= ~src;
		@(negedge clk_i);
		got = {wb_valid_i, exc_res_i, exc_dis_i, wb_data_i};
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the accumulator extraction unit.
`include "acc_extract_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
	localparam logic [127:0] A1 = {64'hfedc_ba98_7654_3210, 64'h0123_4567_89ab_cdef};
	localparam logic [127:0] A2 = 128'h3fff_0000_0000_0000_0000_0000_8000_0001;
	localparam logic [127:0] A3 = 128'hffff_ffff_ffff_ffff_8000_0000_0000_8000;
	logic        clk;
	logic        rst;
	logic        en;
	logic [7:0]  addr;
	logic [63:0] wdata;
	logic        wr;
	logic        rd;
	logic        iv;
	logic [31:0] instr;
	logic [63:0] src;
	logic [63:0] rdata;
	logic        wbv;
	logic [63:0] wbdata;
	logic        exr;
	logic        exd;
	logic [63:0] d;
	int          errors;
	int          checked;
	accumulator_extract_unit u_accumulator_extract_unit (.MCLK_I(clk), .RST_I(rst), .ISSUE_VALID_I(iv),
		.INSTR_I(instr), .SRC_VALUE_I(src), .EXT_ENABLE_I(en), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .WB_VALID_O(wbv), .WB_DEST_O(),
		.WB_DATA_O(wbdata), .EXC_RESERVED_O(exr), .EXC_DISABLED_O(exd));
	pipe_model u_pipe (.clk_i(clk), .wb_valid_i(wbv), .wb_data_i(wbdata), .exc_res_i(exr), .exc_dis_i(exd),
		.issue_valid_o(iv), .instr_o(instr), .src_o(src));
	// Register bus write and read.
	task automatic wreg(input logic [7:0] a, input logic [63:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// Instruction word with destination seven.
	function automatic logic [31:0] op(input logic [4:0] sub, input logic [4:0] f, input logic [1:0] ac);
		return {`MAJOR_GROUP, f, 5'h07, 3'h0, ac, sub, `FUNC_EXTRACT};
	endfunction
	// Expected shift result; mode is round, saturate, word.
	function automatic logic [63:0] exp_val(input logic [127:0] acc, input logic [4:0] sh, input logic [2:0] m,
		output logic o);
		logic [128:0] t;
		t = $signed({acc, 1'b0}) >>> sh;
		t = t + 129'(m[2]);
		o = m[0] ? (t[128:32] != '0 && t[128:32] != '1) : (t[128:64] != '0 && t[128:64] != '1);
		o = o & m[2];
		if (m[0]) begin
			if (o && m[1]) t[32:1] = t[128] ? `SAT_W_MIN : `SAT_W_MAX;
			return {{32{t[32]}}, t[32:1]};
		end
		if (o && m[1]) t[64:1] = t[128] ? `SAT_DW_MIN : `SAT_DW_MAX;
		return t[64:1];
	endfunction
	// Reset values and the register map.
	task automatic t_regs();
		rreg(`OFS_STATUS);
		`CHK(d, 64'h0)
		wreg(8'h20, A1[127:64]);
		wreg(8'h28, A1[63:0]);
		rreg(8'h28);
		`CHK(d, A1[63:0])
		rreg(8'h08);
		`CHK(d, 64'h0)
	endtask
	// Field extraction: valid, failed, plain and boundary wrap.
	task automatic t_field();
		wreg(`OFS_STATUS, 64'd20);
		u_pipe.issue(op(`SUB_VAR_DEC, 5'h0, 2'd1), 64'hffff_ffff_ffff_ffc3);
		`CHK(u_pipe.got, {3'b100, 64'(A1[20:17])})
		rreg(`OFS_STATUS);
		`CHK(d, 64'd16)
		u_pipe.issue(op(`SUB_VAR_DEC, 5'h0, 2'd1), 64'd20);
		`CHK(u_pipe.got[66], 1'b1)
		rreg(`OFS_STATUS);
		`CHK(d, 64'h4010)
		u_pipe.issue(op(`SUB_VAR_FIELD, 5'h0, 2'd1), 64'd16);
		`CHK(u_pipe.got[63:0], 64'(A1[16:0]))
		rreg(`OFS_STATUS);
		`CHK(d, 64'd16)
		u_pipe.issue(op(`SUB_VAR_DEC, 5'h0, 2'd1), 64'd16);
		rreg(`OFS_STATUS);
		`CHK(d, 64'h7f)
	endtask
	// Every shift form on two accumulators and three shifts.
	task automatic t_shift();
		logic [4:0] subs [6] = '{`SUB_DW, `SUB_DW_RND, `SUB_DW_SAT, `SUB_W, `SUB_W_RND, `SUB_W_SAT};
		logic [2:0] mode [6] = '{3'b000, 3'b100, 3'b110, 3'b001, 3'b101, 3'b111};
		logic [4:0] shs [3] = '{5'd0, 5'd4, 5'd31};
		logic [127:0] acc;
		logic [63:0] e;
		logic o;
		logic stk;
		stk = 1'b0;
		wreg(8'h30, A2[127:64]);
		wreg(8'h38, A2[63:0]);
		wreg(8'h40, A3[127:64]);
		wreg(8'h48, A3[63:0]);
		for (int a = 2; a < 4; a++) begin
			acc = (a == 2) ? A2 : A3;
			for (int s = 0; s < 3; s++) begin
				for (int k = 0; k < 6; k++) begin
					e = exp_val(acc, shs[s], mode[k], o);
					stk |= o;
					u_pipe.issue(op(subs[k], shs[s], 2'(a)), 64'h0);
					`CHK(u_pipe.got[63:0], e)
					rreg(`OFS_STATUS);
					`CHK(d[23], stk)
				end
			end
		end
		rreg(8'h38);
		`CHK(d, A2[63:0])
	endtask
	// Disabled, reserved and foreign instructions.
	task automatic t_refuse();
		@(posedge clk);
		en <= 1'b0;
		u_pipe.issue(op(`SUB_VAR_DEC, 5'h0, 2'd1), 64'h3);
		`CHK(u_pipe.got[66:64], 3'b001)
		rreg(`OFS_STATUS);
		`CHK(d, 64'h80_007f)
		@(posedge clk);
		en <= 1'b1;
		u_pipe.issue(op(5'h01, 5'h0, 2'd0), 64'h0);
		`CHK(u_pipe.got[66:64], 3'b010)
		u_pipe.issue(op(`SUB_DW, 5'h0, 2'd0) ^ 32'h0400_0000, 64'h0);
		`CHK(u_pipe.got[66:64], 3'b000)
	endtask
	// Verdict and end of run.
	task automatic stop_test();
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Main sequence.
	initial begin
		rst = 1'b1;
		en = 1'b1;
		addr = 8'h0;
		wdata = 64'h0;
		wr = 1'b0;
		rd = 1'b0;
		errors = 0;
		checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_field();
		t_shift();
		t_refuse();
		stop_test();
	end
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
